// *** hdl/clk_pwr_pkg.sv ***
/*
  Shared constants for the system clock and power-mode controller:
  register offsets, field positions, reset values, mode encodings, timing.
  Assumes a single 100 MHz register clock and APB access with 32-bit data.
*/
package clk_pwr_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] SYSTEM_CLOCK_MODE_OFS = 12'h000;
  localparam logic [11:0] POWER_CONTROL_OFS = 12'h004;
  localparam logic [11:0] CLOCK_STATUS_OFS = 12'h008;

  // ---------------------------------------------------------------
  // system_clock_mode fields
  // ---------------------------------------------------------------
  localparam int DIV_SEL_LSB = 5;
  localparam int SLOW_RDY_BIT = 3;
  localparam int FAST_RDY_BIT = 2;
  localparam int IDLE_EN_BIT = 1;
  localparam int FAST_SEL_BIT = 0;
  localparam logic [2:0] DIV_SEL_RST = 3'h0;
  localparam logic IDLE_EN_RST = 1'b1;
  localparam logic FAST_SEL_RST = 1'b1;

  // ---------------------------------------------------------------
  // power control fields
  // ---------------------------------------------------------------
  localparam int KEEP_BIT = 7;
  localparam int FREQ_SEL_LSB = 4;
  localparam int LVR_FLAG_BIT = 2;
  localparam int VCTRL_FLAG_BIT = 1;
  localparam int WDT_FLAG_BIT = 0;
  localparam logic KEEP_RST = 1'b0;
  localparam logic [1:0] FREQ_SEL_RST = 2'h0;
  localparam logic HAS_FREQ_SEL = 1'b1;

  // ---------------------------------------------------------------
  // status register fields and wake pin idle level
  // ---------------------------------------------------------------
  localparam int STAT_SRC_LSB = 0;
  localparam int STAT_PWR_DOWN_BIT = 4;
  localparam int STAT_TIMEOUT_BIT = 5;
  localparam logic [7:0] PORTA_IDLE = 8'hFF;

  // ---------------------------------------------------------------
  // divider field encodings, fast oscillator frequencies and clock source codes
  // ---------------------------------------------------------------
  localparam logic [2:0] DIV_SLOW_HI = 3'h1;
  localparam logic [2:0] DIV_BY64 = 3'h2;
  localparam logic [1:0] FREQ_8M = 2'h0;
  localparam logic [1:0] FREQ_16M = 2'h1;
  localparam logic [1:0] FREQ_12M = 2'h2;
  localparam logic [2:0] SRC_SLOW = 3'h0;
  localparam logic [2:0] SRC_FAST = 3'h7;

  // ---------------------------------------------------------------
  // oscillator settling, in oscillator cycles
  // ---------------------------------------------------------------
  localparam logic [4:0] FAST_SETTLE_CYC = 5'h0F;
  localparam logic [1:0] SLOW_SETTLE_CYC = 2'h1;

  // power state, gray along run -> halted -> waking
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_WAKE = 2'b11
  } pwr_state_t;

  // operating mode seen from outside
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_SLOW = 3'h1,
    MODE_IDLE_STOP = 3'h2,
    MODE_IDLE_RUN = 3'h3,
    MODE_SLEEP = 3'h4
  } op_mode_t;

endpackage

// *** hdl/sys_clock_power_mode_ctrl.sv ***
/*
  System clock source and low-power mode controller.
  Holds the clock-mode and power-control registers behind an APB slave,
  picks the system clock source and divider, gates clocks in halt modes,
  tracks oscillator settling and keeps the reset-cause flags.
  Assumes the oscillators, divider taps and clock gates sit outside and
  that their edges arrive as one-cycle tick pulses on REF_CLK_IN.
*/
// Design decisions made here: the APB slave port and the address map.
// Function
// - with fast select low, divider 000/001 slow, 010..111 fast/64 down to /2
// - fast select high uses undivided fast clock, otherwise the divider choice
// - moving from fast to slow clock switches the fast oscillator off
// - with fast oscillator stopped no divided fast clocks reach peripherals
// - slow ready flag rises 1 to 2 slow cycles after reset or wake
// - fast ready clears at power-on and halt-stop, rises after 15-16 cycles
// - halt enters idle when idle enable set, else sleep
// - idle with clock keep runs system clock; without it both stop
// - fast frequency field: 00 8, 01 16, 10 12, 11 8 MHz
// - low-voltage reset flag set by event, cleared only by software zero or SRST_IN
// - undefined voltage-control value sets its flag and requests reset
// - watchdog-control software reset sets its flag, cleared by software zero
// - sleep stops system and time-base clocks, slow clock keeps running
// - clock-stopped idle stops system clock, time-base and slow keep running
// - clock-running idle keeps system and slow clocks, CPU halted
// - entering any halt mode clears watchdog counter, which resumes
// - entering any halt mode sets power-down flag, clears timeout flag
// - halt modes keep memory, registers and port outputs unchanged
// - unimplemented register bits read as zero
// - slow oscillator stays enabled after power-on, no way to stop it
// - wake on enabled port-A falling edge, interrupt or watchdog overflow
module sys_clock_power_mode_ctrl
  import clk_pwr_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic SRST_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // oscillator edge ticks and clock safe-phase marks
  input wire logic FAST_TICK_IN,
  input wire logic SLOW_TICK_IN,
  input wire logic OLD_CLK_SAFE_IN,
  input wire logic NEW_CLK_SAFE_IN,
  // cpu and system events
  input wire logic HALT_IN,
  input wire logic [7:0] PORTA_WAKE_EN_IN,
  input wire logic [7:0] PORTA_PIN_IN,
  input wire logic IRQ_IN,
  input wire logic WDT_OVERFLOW_IN,
  input wire logic LOW_VOLTAGE_IN,
  input wire logic VCTRL_UNDEFINED_IN,
  input wire logic WDT_CTRL_RESET_IN,
  // clock controls
  output logic FAST_OSC_EN_OUT,
  output logic SLOW_OSC_EN_OUT,
  output logic [2:0] SYS_CLK_SEL_OUT,
  output logic FAST_DIV_EN_OUT,
  output logic SYS_CLK_EN_OUT,
  output logic TIMEBASE_CLK_EN_OUT,
  output logic CPU_RUN_OUT,
  output logic [1:0] FAST_FREQ_SEL_OUT,
  output logic [5:0] FAST_FREQ_MHZ_OUT,
  // watchdog, status and reset
  output logic WDT_CLEAR_OUT,
  output logic POWER_DOWN_FLAG_OUT,
  output logic WDT_TIMEOUT_FLAG_OUT,
  output logic SOFT_RESET_OUT,
  output logic HOLD_STATE_OUT,
  output logic [2:0] OP_MODE_OUT
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [2:0] div_sel_reg;
  logic idle_en_reg;
  logic fast_sel_reg;
  logic keep_reg;
  logic [1:0] freq_sel_reg;
  logic lvr_flag_reg;
  logic vctrl_flag_reg;
  logic wdt_flag_reg;
  logic slow_rdy_reg;
  logic fast_rdy_reg;
  logic [1:0] slow_cnt_reg;
  logic [4:0] fast_cnt_reg;
  pwr_state_t state_reg;
  pwr_state_t state_next;
  logic [2:0] cur_src_reg;
  logic pwr_down_reg;
  logic wdt_timeout_reg;
  logic [7:0] porta_prev_reg;
  logic wr_en;
  logic wr_mode;
  logic wr_ctrl;
  logic want_fast;
  logic cur_fast;
  logic halted;
  logic wake;
  logic [2:0] want_src;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // single-cycle access phase keeps the master's wait trivial
  assign PREADY_OUT = 1'b1;
  assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign wr_mode = wr_en & (PADDR_IN == SYSTEM_CLOCK_MODE_OFS);
  assign wr_ctrl = wr_en & (PADDR_IN == POWER_CONTROL_OFS);
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & (PADDR_IN != SYSTEM_CLOCK_MODE_OFS)
    & (PADDR_IN != POWER_CONTROL_OFS) & (PADDR_IN != CLOCK_STATUS_OFS);

  // read data is registered; other bits read zero
  // loading it in the setup cycle lets the access phase end with no wait state
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      PRDATA_OUT <= 32'h0;
    end else if (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN) begin
      PRDATA_OUT <= 32'h0;
      case (PADDR_IN)
        SYSTEM_CLOCK_MODE_OFS: begin
          PRDATA_OUT[DIV_SEL_LSB +: 3] <= div_sel_reg;
          PRDATA_OUT[SLOW_RDY_BIT] <= slow_rdy_reg;
          PRDATA_OUT[FAST_RDY_BIT] <= fast_rdy_reg;
          PRDATA_OUT[IDLE_EN_BIT] <= idle_en_reg;
          PRDATA_OUT[FAST_SEL_BIT] <= fast_sel_reg;
        end
        POWER_CONTROL_OFS: begin
          PRDATA_OUT[KEEP_BIT] <= keep_reg;
          PRDATA_OUT[FREQ_SEL_LSB +: 2] <= freq_sel_reg;
          PRDATA_OUT[LVR_FLAG_BIT] <= lvr_flag_reg;
          PRDATA_OUT[VCTRL_FLAG_BIT] <= vctrl_flag_reg;
          PRDATA_OUT[WDT_FLAG_BIT] <= wdt_flag_reg;
        end
        CLOCK_STATUS_OFS: begin
          PRDATA_OUT[STAT_SRC_LSB +: 3] <= cur_src_reg;
          PRDATA_OUT[STAT_PWR_DOWN_BIT] <= pwr_down_reg;
          PRDATA_OUT[STAT_TIMEOUT_BIT] <= wdt_timeout_reg;
        end
        default: begin
          PRDATA_OUT <= 32'h0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // mode register; ready bits are not written here
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      div_sel_reg <= DIV_SEL_RST;
      idle_en_reg <= IDLE_EN_RST;
      fast_sel_reg <= FAST_SEL_RST;
    end else if (wr_mode) begin
      div_sel_reg <= PWDATA_IN[DIV_SEL_LSB +: 3];
      idle_en_reg <= PWDATA_IN[IDLE_EN_BIT];
      fast_sel_reg <= PWDATA_IN[FAST_SEL_BIT];
    end
  end

  // control register fields
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      keep_reg <= KEEP_RST;
      freq_sel_reg <= FREQ_SEL_RST;
    end else if (wr_ctrl) begin
      keep_reg <= PWDATA_IN[KEEP_BIT];
      if (HAS_FREQ_SEL) begin
        freq_sel_reg <= PWDATA_IN[FREQ_SEL_LSB +: 2];
      end
    end
  end

  // ---------------------------------------------------------------
  // reset-cause flags: hardware set wins over a software clear
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      lvr_flag_reg <= 1'b0;
      vctrl_flag_reg <= 1'b0;
      wdt_flag_reg <= 1'b0;
    end else begin
      if (LOW_VOLTAGE_IN) begin
        lvr_flag_reg <= 1'b1;
      end else if (wr_ctrl & ~PWDATA_IN[LVR_FLAG_BIT]) begin
        lvr_flag_reg <= 1'b0;
      end
      if (VCTRL_UNDEFINED_IN) begin
        vctrl_flag_reg <= 1'b1;
      end else if (wr_ctrl & ~PWDATA_IN[VCTRL_FLAG_BIT]) begin
        vctrl_flag_reg <= 1'b0;
      end
      if (WDT_CTRL_RESET_IN) begin
        wdt_flag_reg <= 1'b1;
      end else if (wr_ctrl & ~PWDATA_IN[WDT_FLAG_BIT]) begin
        wdt_flag_reg <= 1'b0;
      end
    end
  end

  // flags survive the soft reset, so it must not be SRST_IN itself
  assign SOFT_RESET_OUT = VCTRL_UNDEFINED_IN | WDT_CTRL_RESET_IN;

  // ---------------------------------------------------------------
  // power state machine
  // ---------------------------------------------------------------
  // falling edges only; the pin history resets to the idle high so no edge follows reset
  assign wake = (|(PORTA_WAKE_EN_IN & porta_prev_reg & ~PORTA_PIN_IN))
    | IRQ_IN | WDT_OVERFLOW_IN;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (HALT_IN) begin
          state_next = ST_HALT;
        end
      end
      ST_HALT: begin
        if (wake) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // cpu resumes once the chosen source is settled
        if (cur_fast ? fast_rdy_reg : slow_rdy_reg) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      state_reg <= ST_RUN;
      porta_prev_reg <= PORTA_IDLE;
    end else begin
      state_reg <= state_next;
      porta_prev_reg <= PORTA_PIN_IN;
    end
  end

  assign halted = (state_reg == ST_HALT);

  // power-down and timeout status
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      pwr_down_reg <= 1'b0;
      wdt_timeout_reg <= 1'b0;
    end else if (state_reg == ST_RUN && HALT_IN) begin
      pwr_down_reg <= 1'b1;
      wdt_timeout_reg <= 1'b0;
    end else if (halted && WDT_OVERFLOW_IN) begin
      wdt_timeout_reg <= 1'b1;
    end
  end

  // one-cycle watchdog clear on halt entry
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      WDT_CLEAR_OUT <= 1'b0;
    end else begin
      WDT_CLEAR_OUT <= (state_reg == ST_RUN) & HALT_IN;
    end
  end

  // ---------------------------------------------------------------
  // clock source choice and glitch-free switch
  // ---------------------------------------------------------------
  always_comb begin
    if (fast_sel_reg) begin
      want_src = SRC_FAST;
    end else if (div_sel_reg <= DIV_SLOW_HI) begin
      want_src = SRC_SLOW;
    end else begin
      want_src = div_sel_reg - DIV_BY64 + 3'h1;
    end
  end
  // encoding: 0 slow, 1..6 fast/64../2, 7 fast undivided
  assign want_fast = (want_src != SRC_SLOW);
  assign cur_fast = (cur_src_reg != SRC_SLOW);

  // switch only when both clocks sit in a safe phase
  // waiting for fast ready on the way up keeps an unsettled oscillator off the system clock
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      cur_src_reg <= SRC_FAST;
    end else if (want_src != cur_src_reg && OLD_CLK_SAFE_IN && NEW_CLK_SAFE_IN
      && (!want_fast || fast_rdy_reg)) begin
      cur_src_reg <= want_src;
    end
  end
  assign SYS_CLK_SEL_OUT = cur_src_reg;

  // fast osc off on the slow clock or in the stopped halt modes
  assign FAST_OSC_EN_OUT = (cur_fast | want_fast) & ~(halted & ~(idle_en_reg & keep_reg));
  assign FAST_DIV_EN_OUT = FAST_OSC_EN_OUT & fast_rdy_reg;
  assign SLOW_OSC_EN_OUT = 1'b1;

  // ---------------------------------------------------------------
  // oscillator settling counters
  // ---------------------------------------------------------------
  // slow side restarts on wake; it never stops so only resettles
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN || (halted && wake)) begin
      slow_cnt_reg <= 2'h0;
      slow_rdy_reg <= 1'b0;
    end else if (SLOW_TICK_IN && !slow_rdy_reg) begin
      slow_cnt_reg <= slow_cnt_reg + 2'h1;
      slow_rdy_reg <= (slow_cnt_reg == SLOW_SETTLE_CYC);
    end
  end

  // any stop of the oscillator restarts the count, so the flag never outlives it
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN || !FAST_OSC_EN_OUT) begin
      fast_cnt_reg <= 5'h0;
      fast_rdy_reg <= 1'b0;
    end else if (FAST_TICK_IN && !fast_rdy_reg) begin
      fast_cnt_reg <= fast_cnt_reg + 5'h1;
      fast_rdy_reg <= (fast_cnt_reg == FAST_SETTLE_CYC);
    end
  end

  // ---------------------------------------------------------------
  // clock gates and mode report
  // ---------------------------------------------------------------
  assign CPU_RUN_OUT = (state_reg == ST_RUN);
  assign HOLD_STATE_OUT = ~CPU_RUN_OUT;
  assign SYS_CLK_EN_OUT = ~halted | (idle_en_reg & keep_reg);
  assign TIMEBASE_CLK_EN_OUT = ~halted | idle_en_reg;
  assign POWER_DOWN_FLAG_OUT = pwr_down_reg;
  assign WDT_TIMEOUT_FLAG_OUT = wdt_timeout_reg;

  always_comb begin
    if (!halted) begin
      OP_MODE_OUT = cur_fast ? MODE_NORMAL : MODE_SLOW;
    end else if (!idle_en_reg) begin
      OP_MODE_OUT = MODE_SLEEP;
    end else if (keep_reg) begin
      OP_MODE_OUT = MODE_IDLE_RUN;
    end else begin
      OP_MODE_OUT = MODE_IDLE_STOP;
    end
  end

  // frequency decode in MHz
  // the spare code repeats 8 MHz so every field value names a real speed
  assign FAST_FREQ_SEL_OUT = freq_sel_reg;
  always_comb begin
    case (freq_sel_reg)
      FREQ_8M: FAST_FREQ_MHZ_OUT = 6'h08;
      FREQ_16M: FAST_FREQ_MHZ_OUT = 6'h10;
      FREQ_12M: FAST_FREQ_MHZ_OUT = 6'h0C;
      default: FAST_FREQ_MHZ_OUT = 6'h08;
    endcase
  end

endmodule // sys_clock_power_mode_ctrl

// *** verification/sys_clock_power_mode_ctrl_props.sv ***
/*
  Port checker for the clock and power-mode controller.
  Assumes binding onto the controller; reset is synchronous, active high.
*/
module clk_pwr_props
  import clk_pwr_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic SRST_IN,
  // events
  input wire logic HALT_IN,
  input wire logic VCTRL_UNDEFINED_IN,
  input wire logic WDT_CTRL_RESET_IN,
  // controls and status
  input wire logic CPU_RUN_OUT,
  input wire logic POWER_DOWN_FLAG_OUT,
  input wire logic WDT_TIMEOUT_FLAG_OUT,
  input wire logic WDT_CLEAR_OUT,
  input wire logic [2:0] SYS_CLK_SEL_OUT,
  input wire logic FAST_OSC_EN_OUT,
  input wire logic FAST_DIV_EN_OUT,
  input wire logic SLOW_OSC_EN_OUT,
  input wire logic SYS_CLK_EN_OUT,
  input wire logic TIMEBASE_CLK_EN_OUT,
  input wire logic [1:0] FAST_FREQ_SEL_OUT,
  input wire logic [5:0] FAST_FREQ_MHZ_OUT,
  input wire logic SOFT_RESET_OUT,
  input wire logic [2:0] OP_MODE_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SRST_IN);

  // ---------------------------------------------------------------
  // halt entry
  // ---------------------------------------------------------------
  sequence s_halt_taken;
    HALT_IN && CPU_RUN_OUT;
  endsequence
  sequence s_halted;
    !CPU_RUN_OUT && POWER_DOWN_FLAG_OUT && !WDT_TIMEOUT_FLAG_OUT;
  endsequence
  property p_halt_enter;
    s_halt_taken |=> s_halted;
  endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("halt entry wrong");
  // the clear is a single pulse, so a stuck clear is caught too
  property p_wdt_clear;
    s_halt_taken |=> ##[0:1] WDT_CLEAR_OUT ##1 !WDT_CLEAR_OUT;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear missing");

  // ---------------------------------------------------------------
  // clock gating per mode, frequency decode and soft reset
  // ---------------------------------------------------------------
  property p_sleep;
    OP_MODE_OUT == MODE_SLEEP |-> !SYS_CLK_EN_OUT && !TIMEBASE_CLK_EN_OUT;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");
  property p_idle_stop;
    OP_MODE_OUT == MODE_IDLE_STOP |-> !SYS_CLK_EN_OUT && TIMEBASE_CLK_EN_OUT;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("idle-stop clocks wrong");
  property p_idle_run;
    OP_MODE_OUT == MODE_IDLE_RUN |-> SYS_CLK_EN_OUT && !CPU_RUN_OUT;
  endproperty
  a_idle_run: assert property (p_idle_run) else $error("idle-run clocks wrong");
  property p_slow_on;
    SLOW_OSC_EN_OUT;
  endproperty
  a_slow_on: assert property (p_slow_on) else $error("slow oscillator stopped");
  // only the moment of switching to slow is checked: going back, fast runs early
  property p_fast_off;
    SYS_CLK_SEL_OUT == 3'h0 && $past(SYS_CLK_SEL_OUT) != 3'h0 |->
      !FAST_OSC_EN_OUT && !FAST_DIV_EN_OUT;
  endproperty
  a_fast_off: assert property (p_fast_off) else $error("fast clock left on");
  property p_freq;
    FAST_FREQ_MHZ_OUT == (FAST_FREQ_SEL_OUT == FREQ_16M ? 6'h10 :
      FAST_FREQ_SEL_OUT == FREQ_12M ? 6'h0C : 6'h08);
  endproperty
  a_freq: assert property (p_freq) else $error("frequency decode wrong");
  property p_soft_reset;
    VCTRL_UNDEFINED_IN || WDT_CTRL_RESET_IN |-> SOFT_RESET_OUT;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset missing");
endmodule // clk_pwr_props

bind sys_clock_power_mode_ctrl clk_pwr_props clk_pwr_props_i (.*);

// *** verification/sys_clock_power_mode_ctrl_test.sv ***
/*
  Self-checking bench for the clock and power-mode controller.
  Assumes the checker is bound separately; APB slave answers with no wait.
*/
module sys_clock_power_mode_ctrl_test
  import clk_pwr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic REF_CLK_IN, SRST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT, PSLVERR_OUT;
  logic FAST_TICK_IN, SLOW_TICK_IN, OLD_CLK_SAFE_IN, NEW_CLK_SAFE_IN, HALT_IN, IRQ_IN;
  logic WDT_OVERFLOW_IN, LOW_VOLTAGE_IN, VCTRL_UNDEFINED_IN, WDT_CTRL_RESET_IN;
  logic FAST_OSC_EN_OUT, SLOW_OSC_EN_OUT, FAST_DIV_EN_OUT, SYS_CLK_EN_OUT;
  logic TIMEBASE_CLK_EN_OUT, CPU_RUN_OUT, WDT_CLEAR_OUT, POWER_DOWN_FLAG_OUT;
  logic WDT_TIMEOUT_FLAG_OUT, SOFT_RESET_OUT, HOLD_STATE_OUT, err;
  logic [1:0] FAST_FREQ_SEL_OUT;
  logic [2:0] SYS_CLK_SEL_OUT, OP_MODE_OUT;
  logic [5:0] FAST_FREQ_MHZ_OUT;
  logic [7:0] PORTA_WAKE_EN_IN, PORTA_PIN_IN;
  logic [11:0] PADDR_IN;
  logic [31:0] PWDATA_IN, PRDATA_OUT, rdata;
  logic [5:0] mhz [4] = '{6'h08, 6'h10, 6'h0C, 6'h08};
  op_mode_t hm [3] = '{MODE_SLEEP, MODE_IDLE_STOP, MODE_IDLE_RUN};
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;

  sys_clock_power_mode_ctrl sys_clock_power_mode_ctrl_i (.*);

  // clock
  initial begin
    REF_CLK_IN = 1'b0;
    forever #5 REF_CLK_IN = ~REF_CLK_IN;
  end

  // hang guard, well above the roughly 700 cycles the run needs
  always @(posedge REF_CLK_IN) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task complete_run;
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task cyc;
    @(posedge REF_CLK_IN);
  endtask

  // one apb transfer; an idle cycle follows so strobes never re-rise in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL_IN <= 1'b1;
    PWRITE_IN <= w;
    PADDR_IN <= a;
    PWDATA_IN <= d;
    cyc;
    PENABLE_IN <= 1'b1;
    do cyc; while (PREADY_OUT !== 1'b1);
    rdata = PRDATA_OUT;
    err = PSLVERR_OUT;
    PSEL_IN <= 1'b0;
    PENABLE_IN <= 1'b0;
    cyc;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  // oscillator ticks: nf fast and ns slow, one per cycle
  task pulse(input int nf, input int ns);
    for (int i = 0; i < nf || i < ns; i++) begin
      FAST_TICK_IN <= i < nf;
      SLOW_TICK_IN <= i < ns;
      cyc;
    end
    FAST_TICK_IN <= 1'b0;
    SLOW_TICK_IN <= 1'b0;
    cyc;
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    {SRST_IN, OLD_CLK_SAFE_IN, NEW_CLK_SAFE_IN} = 3'h7;
    {PSEL_IN, PENABLE_IN, PWRITE_IN, FAST_TICK_IN, SLOW_TICK_IN, HALT_IN, IRQ_IN} = 7'h00;
    {WDT_OVERFLOW_IN, LOW_VOLTAGE_IN, VCTRL_UNDEFINED_IN, WDT_CTRL_RESET_IN} = 4'h0;
    {PADDR_IN, PWDATA_IN} = 44'h0;
    PORTA_WAKE_EN_IN = 8'h01;
    PORTA_PIN_IN = 8'hFF;
    repeat (20) cyc;
    SRST_IN <= 1'b0;
    cyc;
    rd(POWER_CONTROL_OFS, 32'h00);
    rd(CLOCK_STATUS_OFS, 32'h07);
    apb(1'b0, 12'h00C, 32'h0);
    chk(err, 1'b1);
    chk(rdata, 32'h0);
    // settle counts just short of, then at, the ready point
    pulse(15, 1);
    rd(SYSTEM_CLOCK_MODE_OFS, 32'h03);
    pulse(1, 1);
    rd(SYSTEM_CLOCK_MODE_OFS, 32'h0F);
    for (int d = 0; d < 8; d++) begin
      apb(1'b1, SYSTEM_CLOCK_MODE_OFS, {24'h0, 3'(d), 5'h02});
      pulse(40, 40);
      chk(SYS_CLK_SEL_OUT, d < 2 ? 0 : d - 1);
      chk(FAST_DIV_EN_OUT, d > 1);
    end
    // ready bits and upper bits are written as junk and must not stick;
    // the switch back to fast waits while either clock is outside its safe phase
    {OLD_CLK_SAFE_IN, NEW_CLK_SAFE_IN} <= 2'h2;
    apb(1'b1, SYSTEM_CLOCK_MODE_OFS, 32'hFFFF_FF13);
    pulse(40, 40);
    chk(SYS_CLK_SEL_OUT, 3'h6);
    {OLD_CLK_SAFE_IN, NEW_CLK_SAFE_IN} <= 2'h1;
    pulse(4, 4);
    chk(SYS_CLK_SEL_OUT, 3'h6);
    {OLD_CLK_SAFE_IN, NEW_CLK_SAFE_IN} <= 2'h3;
    pulse(40, 40);
    chk(SYS_CLK_SEL_OUT, 3'h7);
    rd(SYSTEM_CLOCK_MODE_OFS, 32'h0F);
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, POWER_CONTROL_OFS, {26'h0, 2'(f), 4'h0});
      rd(POWER_CONTROL_OFS, {26'h0, 2'(f), 4'h0});
      chk(FAST_FREQ_MHZ_OUT, mhz[f]);
    end
    apb(1'b1, POWER_CONTROL_OFS, 32'h0);
    {LOW_VOLTAGE_IN, VCTRL_UNDEFINED_IN, WDT_CTRL_RESET_IN} <= 3'h7;
    cyc;
    {LOW_VOLTAGE_IN, VCTRL_UNDEFINED_IN, WDT_CTRL_RESET_IN} <= 3'h0;
    cyc;
    rd(POWER_CONTROL_OFS, 32'h07);
    apb(1'b1, POWER_CONTROL_OFS, 32'h06);
    rd(POWER_CONTROL_OFS, 32'h06);
    apb(1'b1, POWER_CONTROL_OFS, 32'h00);
    rd(POWER_CONTROL_OFS, 32'h00);
    // sleep, idle-stop, idle-run; each woken by a different source
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, SYSTEM_CLOCK_MODE_OFS, {30'h0, m > 0, 1'b1});
      apb(1'b1, POWER_CONTROL_OFS, m == 2 ? 32'h80 : 32'h00);
      HALT_IN <= 1'b1;
      cyc;
      HALT_IN <= 1'b0;
      cyc;
      chk(OP_MODE_OUT, hm[m]);
      chk({CPU_RUN_OUT, POWER_DOWN_FLAG_OUT, HOLD_STATE_OUT}, 3'h3);
      chk({SYS_CLK_EN_OUT, TIMEBASE_CLK_EN_OUT}, {m == 2, m > 0});
      // a falling edge on a pin whose wake enable is clear must not wake
      PORTA_PIN_IN <= 8'hFD;
      repeat (2) cyc;
      chk(CPU_RUN_OUT, 1'b0);
      WDT_OVERFLOW_IN <= m == 0;
      PORTA_PIN_IN <= m == 1 ? 8'hFE : 8'hFF;
      IRQ_IN <= m == 2;
      pulse(40, 40);
      chk({CPU_RUN_OUT, OP_MODE_OUT}, {1'b1, MODE_NORMAL});
      chk(WDT_TIMEOUT_FLAG_OUT, m == 0);
      {WDT_OVERFLOW_IN, IRQ_IN} <= 2'h0;
      PORTA_PIN_IN <= 8'hFF;
      cyc;
    end
    rd(CLOCK_STATUS_OFS, 32'h17);
    complete_run;
  end
endmodule // sys_clock_power_mode_ctrl_test
